// ---- rtl/dbat_pkg.sv ----
// dbat_pkg: shared constants and types of the dram bank address and timing block
package dbat_pkg;
  localparam int DBAT_BANKS = 8;
  localparam int DBAT_WB_DEPTH = 16;
  localparam logic [4:0] DBAT_WB_FULL = 5'h10;
  // precharge and ras-to-cas choices, in host clocks
  localparam logic [3:0] DBAT_TRP_SHORT = 4'h3;
  localparam logic [3:0] DBAT_TRP_LONG = 4'h4;
  localparam logic [3:0] DBAT_TRCD_SHORT = 4'h2;
  localparam logic [3:0] DBAT_TRCD_LONG = 4'h3;
  // column phase length: hit lead-off (read 4, write 5) minus the decide clock
  localparam logic [3:0] DBAT_RD_COL_CLKS = 4'h3;
  localparam logic [3:0] DBAT_WR_COL_CLKS = 4'h4;
  // 32 kbyte segments, address bits 29:15
  localparam logic [14:0] DBAT_SEG_SMM_LOW = 15'h0007;
  localparam logic [14:0] DBAT_SEG_A_LOW = 15'h0014;
  localparam logic [14:0] DBAT_SEG_B_LOW = 15'h0016;
  localparam logic [14:0] DBAT_SEG_B_HIGH = 15'h0017;
  localparam logic [14:0] DBAT_SEG_D_LOW = 15'h001a;
  localparam logic [14:0] DBAT_SEG_D_HIGH = 15'h001b;

  typedef enum logic [2:0] {
    MAP_N64 = 3'h0,
    MAP_N32 = 3'h1,
    MAP_ASYM16 = 3'h2,
    MAP_N32_16 = 3'h3,
    MAP_SD64_13 = 3'h4,
    MAP_SD64_11 = 3'h5,
    MAP_SD16 = 3'h6
  } dbat_map_t;

  // top: exclusive upper bound in 2 mbyte units
  typedef struct packed {
    dbat_map_t mode;
    logic width32;
    logic hi_half;
    logic [9:0] top;
  } dbat_bank_cfg_t;

  typedef struct packed {
    logic write;
    logic [29:3] qaddr;
    logic [7:0] be;
    logic [63:0] data;
  } dbat_req_t;

  typedef struct packed {
    logic [29:3] qaddr;
    logic [7:0] be;
    logic [63:0] data;
  } dbat_wb_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DECIDE = 5'h02,
    ST_PRECH = 5'h04,
    ST_ROW = 5'h08,
    ST_COL = 5'h10
  } dbat_state_t;
endpackage

// ---- rtl/dbat_addr_map.sv ----
// dbat_addr_map: host address to multiplexed row and column address
`timescale 1ns/100ps
module dbat_addr_map import dbat_pkg::*; (
  input wire logic [29:2] addr_i,
  input wire dbat_map_t mode_i,
  input wire logic has_64m_i,
  output logic [13:0] row_o,
  output logic [13:0] col_o
);
  logic [29:2] a;
  assign a = addr_i;

  // one translation per bank organisation
  always_comb begin
    row_o = 14'h0000;
    col_o = 14'h0000;
    case (mode_i)
      MAP_N64: begin
        row_o[11] = has_64m_i ? a[25] : a[24];
        row_o[10:0] = {a[22], a[11], a[20:12]};
        col_o[11:0] = {2'b00, a[23], a[21], a[10:3]};
      end
      MAP_N32: begin
        row_o[11] = has_64m_i ? a[24] : a[23];
        row_o[10:0] = {a[22], a[11], a[20:12]};
        col_o[11:0] = {2'b00, a[21], a[10:2]};
      end
      MAP_ASYM16: begin
        row_o[11:0] = {a[22], a[21], a[11], a[20:12]};
        col_o[11:0] = {a[23], a[10:3], 3'b000};
      end
      MAP_N32_16: begin
        row_o[11:0] = {a[10], a[21], a[11], a[20:12]};
        col_o[11:0] = {a[22], a[4], a[9:5], a[2], a[3], 3'b000};
      end
      MAP_SD64_13: begin
        row_o = {a[23], a[24], a[11], a[22:12]};
        col_o[11:0] = {a[11], 1'b0, a[24], a[23], a[10], a[9:3]};
      end
      MAP_SD64_11: begin
        row_o = {1'b0, a[23], a[11], a[22:12]};
        col_o[11:0] = {a[11], 1'b0, a[24], a[23], a[10], a[9:3]};
      end
      MAP_SD16: begin
        row_o[11:0] = {a[11], a[22:12]};
        col_o[11:0] = {a[11], 1'b0, a[24], a[23], a[10], a[9:3]};
      end
      default: begin
        row_o = 14'h0000;
        col_o = 14'h0000;
      end
    endcase
  end
endmodule

// ---- rtl/dbat_ctrl.sv ----
// dbat_ctrl: dram bank decode, merging write buffer and lead-off timing
`timescale 1ns/100ps
module dbat_ctrl import dbat_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire dbat_req_t cpu_req_i,
  input wire logic cpu_valid_i,
  output logic cpu_ready_o,
  input wire dbat_req_t pci_req_i,
  input wire logic pci_valid_i,
  output logic pci_ready_o,
  output logic rd_valid_o,
  output logic rd_src_pci_o,
  output logic [63:0] rd_data_o,
  input wire dbat_bank_cfg_t [DBAT_BANKS-1:0] bank_cfg_i,
  input wire logic cfg_trp_long_i,
  input wire logic cfg_trcd_long_i,
  input wire logic cfg_chk_early_i,
  input wire logic cfg_spec_early_i,
  input wire logic cfg_has_64m_i,
  input wire logic smm_mode_i,
  input wire logic [2:0] smm_remap_i,
  output logic cpu_noncache_o,
  output logic [4:0] wb_count_o,
  output logic [13:0] dram_mux_addr_o,
  output logic [1:0] dram_mux_addr_dup_o,
  output logic [7:0] ras_n_o,
  output logic [7:0] cas_n_o,
  output logic we_n_o,
  input wire logic [63:0] mem_dq_i,
  output logic [63:0] mem_dq_o,
  output logic mem_dq_oe_o
);
  dbat_req_t sel, rd_q, next_rd_q;
  logic sel_valid, nc_hit, take, post, rd_pend, next_rd_pend, rd_src, next_rd_src, nc, next_nc;
  logic [14:0] seg;
  dbat_wb_t wb [DBAT_WB_DEPTH];
  dbat_wb_t next_wb [DBAT_WB_DEPTH];
  logic [3:0] head, tail, next_head, next_tail, midx;
  logic [4:0] wb_cnt, next_wb_cnt;
  logic [DBAT_WB_DEPTH-1:0] wvalid, mhit, rhit;
  dbat_state_t st, next_st;
  logic [3:0] cnt, next_cnt, trp, trcd, colc, extra;
  logic op_write, next_op_write, wr_done, fin;
  logic [29:2] op_addr, next_op_addr;
  logic [7:0] op_be, next_op_be, lanes, next_cas_n, next_ras_n;
  logic [63:0] op_data, next_op_data, next_rd_data, next_dq;
  logic open_v, next_open_v, hit, bank_ok, two_beat, next_rd_valid, next_we_n, next_oe;
  logic [2:0] open_bank, next_open_bank, op_bank;
  logic [13:0] open_row, next_open_row, row, col, next_ma;
  logic [DBAT_BANKS-1:0] inb;
  logic [3:0] be_dw;
  logic [31:0] half, dw;
  dbat_bank_cfg_t bcfg;

  ////////////////////////////////////////////////////////////////
  // request select; cpu wins, smm remap applies to cpu only
  always_comb begin
    sel = cpu_valid_i ? cpu_req_i : pci_req_i;
    sel_valid = cpu_valid_i | pci_valid_i;
    seg = sel.qaddr[29:15];
    nc_hit = 1'b0;
    if (cpu_valid_i && smm_mode_i) begin
      if (smm_remap_i[0] && seg == DBAT_SEG_B_LOW) begin
        sel.qaddr[29:15] = DBAT_SEG_SMM_LOW;
        nc_hit = 1'b1;
      end else if (smm_remap_i[1] && seg >= DBAT_SEG_A_LOW && seg <= DBAT_SEG_B_HIGH) begin
        nc_hit = 1'b1;
      end else if (smm_remap_i[2] && seg >= DBAT_SEG_D_LOW && seg <= DBAT_SEG_D_HIGH) begin
        sel.qaddr[29:15] = 15'(seg - DBAT_SEG_D_LOW + DBAT_SEG_B_LOW);
        nc_hit = 1'b1;
      end
    end
  end

  // one acceptance per cycle; reads wait for the single read slot
  assign take = sel_valid && (sel.write ? (|mhit || wb_cnt != DBAT_WB_FULL) : !rd_pend);
  assign post = take && sel.write;
  assign cpu_ready_o = take && cpu_valid_i;
  assign pci_ready_o = take && !cpu_valid_i;
  assign wb_count_o = wb_cnt;

  ////////////////////////////////////////////////////////////////
  // write buffer entry compare; the entry in flight is not merged into
  genvar gi;
  generate
    for (gi = 0; gi < DBAT_WB_DEPTH; gi++) begin : g_wb
      logic [3:0] off;
      assign off = 4'(gi) - head;
      assign wvalid[gi] = {1'b0, off} < wb_cnt;
      assign mhit[gi] = wvalid[gi] && wb[gi].qaddr == sel.qaddr &&
                        !(op_write && st != ST_IDLE && 4'(gi) == head);
      assign rhit[gi] = wvalid[gi] && wb[gi].qaddr == rd_q.qaddr;
    end
  endgenerate

  // post, merge and retire
  always_comb begin
    next_wb = wb;
    next_head = head;
    next_tail = tail;
    next_wb_cnt = wb_cnt;
    midx = 4'h0;
    for (int i = 0; i < DBAT_WB_DEPTH; i++) begin
      if (mhit[i]) begin
        midx = 4'(i);
      end
    end
    if (post) begin
      if (|mhit) begin
        for (int b = 0; b < 8; b++) begin
          if (sel.be[b]) begin
            next_wb[midx].data[8*b +: 8] = sel.data[8*b +: 8];
            next_wb[midx].be[b] = 1'b1;
          end
        end
      end else begin
        next_wb[tail] = '{qaddr: sel.qaddr, be: sel.be, data: sel.data};
        next_tail = tail + 4'h1;
        next_wb_cnt = next_wb_cnt + 5'h01;
      end
    end
    if (wr_done) begin
      next_head = head + 4'h1;
      next_wb_cnt = next_wb_cnt - 5'h01;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < DBAT_WB_DEPTH; i++) begin
        wb[i] <= '0;
      end
      head <= 4'h0;
      tail <= 4'h0;
      wb_cnt <= 5'h00;
    end else begin
      wb <= next_wb;
      head <= next_head;
      tail <= next_tail;
      wb_cnt <= next_wb_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // read slot and noncacheable flag
  always_comb begin
    next_rd_pend = rd_pend;
    next_rd_q = rd_q;
    next_rd_src = rd_src;
    next_nc = nc;
    if (take && !sel.write) begin
      next_rd_pend = 1'b1;
      next_rd_q = sel;
      next_rd_src = !cpu_valid_i;
    end else if (fin && !op_write) begin
      next_rd_pend = 1'b0;
    end
    if (take && cpu_valid_i) begin
      next_nc = nc_hit;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rd_pend <= 1'b0;
      rd_q <= '0;
      rd_src <= 1'b0;
      nc <= 1'b0;
    end else begin
      rd_pend <= next_rd_pend;
      rd_q <= next_rd_q;
      rd_src <= next_rd_src;
      nc <= next_nc;
    end
  end

  ////////////////////////////////////////////////////////////////
  // bank decode by ascending top bounds; an empty bank repeats the bound
  generate
    for (gi = 0; gi < DBAT_BANKS; gi++) begin : g_bank
      logic [9:0] lo;
      assign lo = (gi == 0) ? 10'h000 : bank_cfg_i[(gi == 0) ? 0 : gi - 1].top;
      assign inb[gi] = {1'b0, op_addr[29:21]} >= lo && {1'b0, op_addr[29:21]} < bank_cfg_i[gi].top;
    end
  endgenerate

  always_comb begin
    op_bank = 3'h0;
    for (int i = DBAT_BANKS - 1; i >= 0; i--) begin
      if (inb[i]) begin
        op_bank = 3'(i);
      end
    end
  end

  assign bank_ok = |inb;
  assign bcfg = bank_cfg_i[op_bank];

  dbat_addr_map u_map (
    .addr_i(op_addr),
    .mode_i(bcfg.mode),
    .has_64m_i(cfg_has_64m_i),
    .row_o(row),
    .col_o(col)
  );

  // timing choices and lane steering
  always_comb begin
    trp = cfg_trp_long_i ? DBAT_TRP_LONG : DBAT_TRP_SHORT;
    trcd = cfg_trcd_long_i ? DBAT_TRCD_LONG : DBAT_TRCD_SHORT;
    colc = op_write ? DBAT_WR_COL_CLKS : DBAT_RD_COL_CLKS;
    hit = open_v && open_bank == op_bank && open_row == row;
    be_dw = op_addr[2] ? op_be[7:4] : op_be[3:0];
    lanes = !bcfg.width32 ? op_be : (bcfg.hi_half ? {be_dw, 4'h0} : {4'h0, be_dw});
    two_beat = bcfg.width32 && !op_addr[2] && |op_be[7:4];
    half = bcfg.hi_half ? mem_dq_i[63:32] : mem_dq_i[31:0];
    dw = op_addr[2] ? op_data[63:32] : op_data[31:0];
  end

  ////////////////////////////////////////////////////////////////
  // access sequencer; a row stays open after the access (page mode)
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_op_write = op_write;
    next_op_addr = op_addr;
    next_op_be = op_be;
    next_op_data = op_data;
    next_open_v = open_v;
    next_open_bank = open_bank;
    next_open_row = open_row;
    next_rd_data = rd_data_o;
    fin = 1'b0;
    extra = 4'h0;
    case (st)
      ST_IDLE: begin
        // reads first, but never past a buffered write to the same qword
        if (rd_pend && !(|rhit)) begin
          next_op_write = 1'b0;
          next_op_addr = {rd_q.qaddr, ~|rd_q.be[3:0]};
          next_op_be = rd_q.be;
          next_rd_data = 64'h0;
          extra = {3'b000, !cfg_chk_early_i} + {3'b000, !cfg_spec_early_i};
          next_cnt = extra;
          next_st = ST_DECIDE;
        end else if (wb_cnt != 5'h00) begin
          next_op_write = 1'b1;
          next_op_addr = {wb[head].qaddr, ~|wb[head].be[3:0]};
          next_op_be = wb[head].be;
          next_op_data = wb[head].data;
          next_cnt = {3'b000, !cfg_chk_early_i};
          next_st = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else if (!bank_ok) begin
          fin = 1'b1;
        end else if (hit) begin
          next_cnt = colc - 4'h1;
          next_st = ST_COL;
        end else if (open_v) begin
          next_open_v = 1'b0;
          next_cnt = trp - 4'h1;
          next_st = ST_PRECH;
        end else begin
          next_open_v = 1'b1;
          next_open_bank = op_bank;
          next_open_row = row;
          next_cnt = trcd - 4'h1;
          next_st = ST_ROW;
        end
      end
      ST_PRECH: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_open_v = 1'b1;
          next_open_bank = op_bank;
          next_open_row = row;
          next_cnt = trcd - 4'h1;
          next_st = ST_ROW;
        end
      end
      ST_ROW: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_cnt = colc - 4'h1;
          next_st = ST_COL;
        end
      end
      ST_COL: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          if (!op_write && !bcfg.width32) begin
            next_rd_data = mem_dq_i;
          end else if (!op_write && op_addr[2]) begin
            next_rd_data[63:32] = half;
          end else if (!op_write) begin
            next_rd_data[31:0] = half;
          end
          if (two_beat) begin
            next_op_addr[2] = 1'b1;
            next_cnt = colc - 4'h1;
          end else begin
            fin = 1'b1;
          end
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
    if (fin) begin
      next_st = ST_IDLE;
    end
    wr_done = fin && op_write;
    next_rd_valid = fin && !op_write;
  end

  // memory pins follow the sequencer one clock later
  always_comb begin
    next_ras_n = 8'hff;
    if (open_v) begin
      next_ras_n[open_bank] = 1'b0;
    end
    next_ma = (st == ST_COL) ? col : row;
    next_cas_n = (st == ST_COL && cnt != colc - 4'h1) ? ~lanes : 8'hff;
    next_we_n = !(st == ST_COL && op_write);
    next_oe = st == ST_COL && op_write;
    next_dq = bcfg.width32 ? {dw, dw} : op_data;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st <= ST_IDLE;
      cnt <= 4'h0;
      op_write <= 1'b0;
      op_addr <= '0;
      op_be <= 8'h00;
      op_data <= 64'h0;
      open_v <= 1'b0;
      open_bank <= 3'h0;
      open_row <= 14'h0000;
      rd_data_o <= 64'h0;
      rd_valid_o <= 1'b0;
      ras_n_o <= 8'hff;
      cas_n_o <= 8'hff;
      we_n_o <= 1'b1;
      dram_mux_addr_o <= 14'h0000;
      dram_mux_addr_dup_o <= 2'h0;
      mem_dq_o <= 64'h0;
      mem_dq_oe_o <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      op_write <= next_op_write;
      op_addr <= next_op_addr;
      op_be <= next_op_be;
      op_data <= next_op_data;
      open_v <= next_open_v;
      open_bank <= next_open_bank;
      open_row <= next_open_row;
      rd_data_o <= next_rd_data;
      rd_valid_o <= next_rd_valid;
      ras_n_o <= next_ras_n;
      cas_n_o <= next_cas_n;
      we_n_o <= next_we_n;
      dram_mux_addr_o <= next_ma;
      dram_mux_addr_dup_o <= next_ma[1:0];
      mem_dq_o <= next_dq;
      mem_dq_oe_o <= next_oe;
    end
  end

  assign rd_src_pci_o = rd_src;
  assign cpu_noncache_o = nc;

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  logic dec_rd;
  assign dec_rd = st == ST_DECIDE && cnt == 4'h0 && !op_write && bank_ok && !bcfg.width32;

  a_dup_lines: assert property (dram_mux_addr_dup_o == dram_mux_addr_o[1:0])
    else $error("duplicate address lines differ");
  a_wb_bound: assert property (wb_cnt <= DBAT_WB_FULL && (wb_cnt != DBAT_WB_FULL || !post || |mhit))
    else $error("write buffer overfilled");
  a_trp_short: assert property (!cfg_trp_long_i && $rose(&ras_n_o) |-> (&ras_n_o) [*3])
    else $error("precharge shorter than 3");
  a_trp_long: assert property (cfg_trp_long_i && $rose(&ras_n_o) |-> (&ras_n_o) [*4])
    else $error("precharge shorter than 4");
  a_rcd_delay: assert property ($fell(&ras_n_o) |-> (&cas_n_o) [*2] ##1 (!cfg_trcd_long_i || &cas_n_o))
    else $error("cas too soon after ras");
  a_rd_hit_lead: assert property (dec_rd && hit |-> !rd_valid_o [*4] ##1 rd_valid_o)
    else $error("read hit lead-off not 4");
  a_row_miss_lead: assert property (dec_rd && !open_v && !cfg_trcd_long_i |-> ##6 rd_valid_o)
    else $error("read row miss lead-off not 6");
  a_page_miss_lead: assert property (dec_rd && open_v && !hit && !cfg_trp_long_i && !cfg_trcd_long_i
                                     |-> ##9 rd_valid_o)
    else $error("read page miss lead-off not 9");
  a_cas_col_addr: assert property (!(&cas_n_o) |-> !(&ras_n_o) && $stable(dram_mux_addr_o))
    else $error("column address moved under cas");
  a_lane_half: assert property (!(&cas_n_o) && bcfg.width32 |-> cas_n_o[7:4] == 4'hf || cas_n_o[3:0] == 4'hf)
    else $error("32-bit bank drove both halves");
  a_spec_early: assert property (st == ST_IDLE && rd_pend && !(|rhit) && cfg_spec_early_i && cfg_chk_early_i
                                 |=> st == ST_DECIDE && cnt == 4'h0)
    else $error("speculative lead-off not applied");

  c_page_miss: cover property (st == ST_PRECH);
  c_merge: cover property (post && |mhit);
  c_wb_full: cover property (wb_cnt == DBAT_WB_FULL);
  c_two_beat: cover property (st == ST_COL && cnt == 4'h0 && two_beat);
endmodule

// ---- verif/dbat_mem_model.sv ----
// dbat_mem_model: behavioural memory module behind the row and column strobes
`timescale 1ns/100ps
module dbat_mem_model (
  input wire logic clk_sys_i,
  input wire logic [13:0] dram_mux_addr_i,
  input wire logic [7:0] ras_n_i,
  input wire logic [7:0] cas_n_i,
  input wire logic we_n_i,
  input wire logic [63:0] dq_i,
  output logic [63:0] dq_o
);
  logic [63:0] mem [logic [30:0]];
  logic [13:0] row [8];
  logic [7:0] ras_q = 8'hff;
  logic [63:0] junk = 64'h0;
  logic [2:0] bk;
  logic [30:0] key;
  ////////////////////////////////////////
  // lowest open bank picks the latched row
  always_comb begin
    bk = 3'h0;
    for (int i = 7; i >= 0; i--) if (!ras_n_i[i]) bk = 3'(i);
    key = {bk, row[bk], dram_mux_addr_i};
  end
  // released bus shows a moving pattern, never the last word
  always_comb begin
    dq_o = ~junk;
    if (!(&cas_n_i) && we_n_i && mem.exists(key)) dq_o = mem[key];
  end
  ////////////////////////////////////////
  // row latch on ras fall, byte lanes stored under their cas
  always @(posedge clk_sys_i) begin
    junk <= ~junk ^ 64'h5a;
    ras_q <= ras_n_i;
    for (int i = 0; i < 8; i++) if (ras_q[i] && !ras_n_i[i]) row[i] <= dram_mux_addr_i;
    if (!we_n_i && !(&cas_n_i)) begin
      if (!mem.exists(key)) mem[key] = 64'h0;
      for (int l = 0; l < 8; l++) if (!cas_n_i[l]) mem[key][8*l+:8] = dq_i[8*l+:8];
    end
  end
endmodule

// ---- verif/dbat_ctrl_tb.sv ----
// dbat_ctrl_tb: directed checks of lead-off, muxed address, merging and remap
`timescale 1ns/100ps
module dbat_ctrl_tb import dbat_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  dbat_req_t cpu_req = '0;
  dbat_req_t pci_req = '0;
  logic cpu_valid = 1'b0, pci_valid = 1'b0, trp_l = 1'b0, trcd_l = 1'b0;
  logic early = 1'b1, spec = 1'b1, rd_pci = 1'b0, has64 = 1'b0, smm = 1'b0, col_got = 1'b0, dup_ok;
  logic [2:0] remap = 3'h0;
  dbat_bank_cfg_t [DBAT_BANKS-1:0] bank_cfg = '0;
  logic cpu_ready_o, pci_ready_o, rd_valid_o, rd_src_pci_o, cpu_noncache_o, we_n_o, mem_dq_oe_o;
  logic [63:0] rd_data_o, mem_dq_i, mem_dq_o;
  logic [4:0] wb_count_o;
  logic [13:0] dram_mux_addr_o, row_cap, col_cap;
  logic [1:0] dram_mux_addr_dup_o;
  logic [7:0] ras_n_o, cas_n_o, ras_q = 8'hff, cas_q = 8'hff, cas_seen;
  logic [29:0] sm_a [4] = '{30'hb0000, 30'ha0000, 30'hd0000, 30'hb0000};
  logic [63:0] sm_d [4] = '{64'h1, 64'h3, 64'h2, 64'h2};
  int error_cnt = 0, checks_done = 0, cyc = 0;

  dbat_ctrl uut (.clk_sys_i, .reset_i, .cpu_req_i(cpu_req), .cpu_valid_i(cpu_valid), .cpu_ready_o,
    .pci_req_i(pci_req), .pci_valid_i(pci_valid), .pci_ready_o, .rd_valid_o, .rd_src_pci_o, .rd_data_o,
    .bank_cfg_i(bank_cfg), .cfg_trp_long_i(trp_l), .cfg_trcd_long_i(trcd_l), .cfg_chk_early_i(early),
    .cfg_spec_early_i(spec), .cfg_has_64m_i(has64), .smm_mode_i(smm), .smm_remap_i(remap),
    .cpu_noncache_o, .wb_count_o, .dram_mux_addr_o, .dram_mux_addr_dup_o, .ras_n_o, .cas_n_o,
    .we_n_o, .mem_dq_i, .mem_dq_o, .mem_dq_oe_o);
  dbat_mem_model mem (.clk_sys_i, .dram_mux_addr_i(dram_mux_addr_o), .ras_n_i(ras_n_o),
    .cas_n_i(cas_n_o), .we_n_i(we_n_o), .dq_i(mem_dq_o), .dq_o(mem_dq_i));

  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic do_reset();
    reset_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    reset_i <= 1'b0;
  endtask
  task automatic setbank(int m, logic w, logic hi);
    for (int i = 0; i < DBAT_BANKS; i++) bank_cfg[i] <= '{dbat_map_t'(3'(m)), w, hi, 10'h200};
  endtask
  // request held until ready is seen at an edge
  task automatic xfer(bit pci, logic wr, logic [29:0] a, logic [7:0] be, logic [63:0] d);
    int n = 0;
    @(posedge clk_sys_i);
    cpu_req <= '{wr, a[29:3], be, d};
    pci_req <= '{wr, a[29:3], be, d};
    cpu_valid <= !pci;
    pci_valid <= pci;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (!(pci ? pci_ready_o === 1'b1 : cpu_ready_o === 1'b1) && n < 100);
    cpu_valid <= 1'b0;
    pci_valid <= 1'b0;
  endtask
  // latency counts edges after the take edge
  task automatic rd(logic [29:0] a, output logic [63:0] q, output int lat);
    xfer(rd_pci, 1'b0, a, 8'hff, 64'h0);
    lat = 0;
    do begin
      @(posedge clk_sys_i);
      lat++;
    end while (rd_valid_o !== 1'b1 && lat < 100);
    q = rd_data_o;
  endtask
  task automatic drain();
    int n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_count_o !== 5'h0 && n < 500);
  endtask
  // mask in the upper half, expected row in the lower
  function automatic logic [27:0] exp_rc(int m, logic h, logic [29:0] a);
    case (m)
      0: return {14'h0800, 2'h0, h ? a[25] : a[24], 11'h0};
      1: return {14'h0fff, 2'h0, h ? a[24] : a[23], a[22], a[11], a[20:12]};
      2: return {14'h0fff, 2'h0, a[22:21], a[11], a[20:12]};
      3: return {14'h0fff, 2'h0, a[10], a[21], a[11], a[20:12]};
      4: return {14'h3fff, a[23], a[24], a[11], a[22:12]};
      5: return {14'h1fff, 1'b0, a[23], a[11], a[22:12]};
      default: return {14'h0fff, 2'h0, a[11], a[22:12]};
    endcase
  endfunction
  ////////////////////////////////////////
  // strobe watcher and run limit
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      give_verdict();
    end
    if ((ras_q & ~ras_n_o) != 8'h0) begin
      row_cap = dram_mux_addr_o;
      dup_ok = dram_mux_addr_dup_o === dram_mux_addr_o[1:0];
    end
    if (!col_got && &cas_q && !(&cas_n_o)) begin
      col_cap = dram_mux_addr_o;
      col_got = 1'b1;
    end
    cas_seen = cas_seen | ~cas_n_o;
    ras_q = ras_n_o;
    cas_q = cas_n_o;
  end
  ////////////////////////////////////////
  initial begin
    logic [63:0] q;
    logic [27:0] e;
    logic [29:0] a;
    int lat, x;
    setbank(0, 1'b0, 1'b0);
    do_reset();
    check("ras idle", ras_n_o, 8'hff);
    check("idle pins", {cas_n_o, we_n_o, mem_dq_oe_o, rd_valid_o, wb_count_o}, 16'hff80);
    // pci stays out while cpu asks
    cpu_req <= '{1'b1, 27'h40, 8'hff, 64'h0};
    cpu_valid <= 1'b1;
    pci_valid <= 1'b1;
    @(posedge clk_sys_i);
    check("pci refused", pci_ready_o, 0);
    cpu_valid <= 1'b0;
    pci_valid <= 1'b0;
    xfer(0, 1'b1, 30'h100, 8'h0f, 64'h1111_2222_3333_4444);
    xfer(1, 1'b1, 30'h100, 8'hf0, 64'h5555_6666_7777_8888);
    xfer(1, 1'b1, 30'h3fff_fff8, 8'hff, 64'hdead_beef_0bad_f00d);
    drain();
    rd(30'h100, q, lat);
    check("merge", q, 64'h5555_6666_3333_4444);
    // the top qword comes back through the pci side
    rd_pci = 1'b1;
    rd(30'h3fff_fff8, q, lat);
    rd_pci = 1'b0;
    check("top qword", q, 64'hdead_beef_0bad_f00d);
    check("pci source", rd_src_pci_o, 1);
    // lead-off per precharge, ras-to-cas and early choices
    for (int k = 0; k < 6; k++) begin
      trp_l <= k[0];
      trcd_l <= k[1];
      early <= (k < 5);
      spec <= (k < 4);
      do_reset();
      // lead-off plus the idle clock and the edge that samples the pulse; each cleared early bit adds one
      x = 6 + (k > 3) + (k > 4) + (k[1] ? 3 : 2);
      rd(30'h0010_0000, q, lat);
      check("row miss", lat, x);
      check("cpu source", rd_src_pci_o, 0);
      rd(30'h0010_0008, q, lat);
      check("hit", lat, x - (k[1] ? 3 : 2));
      rd(30'h0020_0000, q, lat);
      check("page miss", lat, x + (k[0] ? 4 : 3));
    end
    // row layout of every map mode, column layout of MAP_SD16
    for (int k = 0; k < 14; k++) begin
      a = 30'h0123_4568 + 30'(k) * 30'h0105_3000;
      setbank(k / 2, k / 2 == 1 || k / 2 == 3, 1'b0);
      has64 <= k[0];
      col_got = 1'b0;
      rd(a, q, lat);
      e = exp_rc(k / 2, k[0], a);
      check("row map", (row_cap ^ e[13:0]) & e[27:14], 0);
      check("dup lines", dup_ok, 1);
      if (k / 2 == 6) check("col map", col_cap[11:0], {a[11], 1'b0, a[24:23], a[10:3]});
    end
    // 32-bit banks on either dword half
    for (int h = 0; h < 2; h++) begin
      setbank(1, 1'b1, h[0]);
      xfer(0, 1'b1, 30'h0400_0000 + 30'(h * 8), 8'hff, 64'h0f1e_2d3c_4b5a_6978);
      drain();
      cas_seen = 8'h0;
      rd(30'h0400_0000 + 30'(h * 8), q, lat);
      check("half data", q, 64'h0f1e_2d3c_4b5a_6978);
      check("half lanes", cas_seen, h ? 8'hf0 : 8'h0f);
    end
    // management memory windows
    setbank(0, 1'b0, 1'b0);
    xfer(0, 1'b1, 30'h38000, 8'hff, 64'h1);
    xfer(0, 1'b1, 30'hb0000, 8'hff, 64'h2);
    xfer(0, 1'b1, 30'ha0000, 8'hff, 64'h3);
    drain();
    for (int i = 0; i < 4; i++) begin
      smm <= (i != 3);
      remap <= 3'h1 << i;
      rd(sm_a[i], q, lat);
      check("remap data", q, sm_d[i]);
      check("noncache", cpu_noncache_o, i != 3);
    end
    drain();
    check("wb drained", wb_count_o, 0);
    give_verdict();
  end
endmodule
